// File: pbp_pkg.sv
package pbp_pkg;
    localparam logic [7:0] PBP_CTRL_OFFSET = 8'h1c;
    localparam int PBP_LATCH_BIT = 2;
    localparam int PBP_HV_BIT = 0;
    localparam logic [7:0] PBP_CTRL_RESET = 8'h00;
    localparam logic [12:0] PBP_OPTION_ADDR = 13'h1fdf;
    localparam int PBP_SECURE_BIT = 3;
    localparam logic [12:0] PBP_FIRST_ADDR = 13'h0020;
    localparam logic [12:0] PBP_LAST_ADDR = 13'h1fff;
    localparam logic [12:0] PBP_RAM_LOAD_ADDR = 13'h0050;
    localparam logic [12:0] PBP_RAM_START_ADDR = 13'h0051;
    localparam int PBP_CLK_HZ = 50000000;
    localparam int PBP_BAUD = 9600;
    localparam int PBP_BIT_CYCLES = PBP_CLK_HZ / PBP_BAUD;
    localparam int PBP_PROM_PROGRAM_CONTROL_PULSE_US = 1000;
    localparam int PBP_PROM_PROGRAM_CONTROL_CYCLES =
        PBP_PROM_PROGRAM_CONTROL_PULSE_US * (PBP_CLK_HZ / 1000000);
    typedef enum logic [2:0] {
        PBP_MODE_PROGRAM,
        PBP_MODE_VERIFY,
        PBP_MODE_SECURE_VERIFY,
        PBP_MODE_SECURE_DUMP,
        PBP_MODE_LOAD_RAM,
        PBP_MODE_EXEC_RAM,
        PBP_MODE_DUMP,
        PBP_MODE_IDLE
    } pbp_mode_type;
    function automatic pbp_mode_type pbp_decode_mode(input logic [3:0] sw);
        // sw = {sw_d, sw_c, sw_b, sw_a}
        unique case (sw)
            4'h0: pbp_decode_mode = PBP_MODE_PROGRAM;
            4'h4: pbp_decode_mode = PBP_MODE_VERIFY;
            4'h5: pbp_decode_mode = PBP_MODE_SECURE_VERIFY;
            4'h7: pbp_decode_mode = PBP_MODE_SECURE_DUMP;
            4'h2: pbp_decode_mode = PBP_MODE_LOAD_RAM;
            4'h8: pbp_decode_mode = PBP_MODE_EXEC_RAM;
            4'h6: pbp_decode_mode = PBP_MODE_DUMP;
            default: pbp_decode_mode = PBP_MODE_IDLE;
        endcase
    endfunction
    // on-chip memory map: 0x0020-0x004f, 0x0100-0x1eff, 0x1ff0-0x1fff
    function automatic logic pbp_implemented(input logic [12:0] a);
        pbp_implemented = (a >= 13'h0020 && a <= 13'h004f) ||
            (a >= 13'h0100 && a <= 13'h1eff) ||
            (a >= 13'h1ff0 && a <= 13'h1fff);
    endfunction
endpackage

// File: pbp_uart_tx.sv
`timescale 1ns/1ns
module pbp_uart_tx #(
    parameter int BIT_CYCLES = 5208
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [7:0] data_i,
    output logic busy_o,
    output logic txd_o
);
    logic [9:0] shift;
    logic [3:0] bits_left;
    logic [15:0] cnt;
    assign busy_o = bits_left != 4'h0;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            shift <= 10'h3ff;
            bits_left <= 4'h0;
            cnt <= 16'h0000;
        end else if (start_i && !busy_o) begin
            // one start bit, eight data bits lsb first, one stop bit
            shift <= {1'b1, data_i, 1'b0};
            bits_left <= 4'ha;
            cnt <= 16'(BIT_CYCLES - 1);
        end else if (busy_o) begin
            if (cnt == 16'h0000) begin
                shift <= {1'b1, shift[9:1]};
                bits_left <= bits_left - 4'h1;
                cnt <= 16'(BIT_CYCLES - 1);
            end else begin
                cnt <= cnt - 16'h0001;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            txd_o <= 1'b1;
        end else begin
            txd_o <= busy_o ? shift[0] : 1'b1;
        end
    end
endmodule

// File: pbp_top.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ns
module pbp_top
    import pbp_pkg::*;
#(
    parameter int PROM_PROGRAM_CONTROL_CYCLES = pbp_pkg::PBP_PROM_PROGRAM_CONTROL_CYCLES,
    parameter int BIT_CYCLES = pbp_pkg::PBP_BIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sw_a_i,
    input wire logic sw_b_i,
    input wire logic sw_c_i,
    input wire logic sw_d_i,
    input wire logic [12:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic cpu_write_i,
    output logic [12:0] ext_addr_o,
    input wire logic [7:0] ext_data_i,
    output logic [12:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_write_o,
    input wire logic [7:0] mem_rdata_i,
    output logic vpp_enable_o,
    output logic red_led_o,
    output logic green_led_o,
    output logic txd_o,
    input wire logic rxd_byte_valid_i,
    input wire logic [7:0] rxd_byte_i,
    output logic [12:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic ram_write_o,
    output logic jump_valid_o,
    output logic [12:0] jump_addr_o,
    output logic busy_o,
    output logic fail_o
);
    import pbp_pkg::*;

    typedef enum logic [3:0] {
        ST_START,
        ST_PROM_PROGRAM_CONTROL_RD,
        ST_PROM_PROGRAM_CONTROL_PULSE,
        ST_VER_RD,
        ST_VER_CMP,
        ST_SEC_PULSE,
        ST_DUMP_RD,
        ST_DUMP_SEND,
        ST_DUMP_WAIT,
        ST_LOAD,
        ST_DONE,
        ST_FAIL
    } pbp_state_type;

    pbp_state_type state;
    pbp_mode_type mode;
    logic armed;
    logic latch_arm;
    logic high_voltage_apply;
    logic security_lock;
    logic [12:0] addr;
    logic [12:0] latch_addr;
    logic [7:0] latch_data;
    logic latch_full;
    logic [19:0] timer;
    logic [7:0] load_count;
    logic [7:0] load_seen;
    logic tx_start;
    logic tx_busy;
    logic seq_write;
    logic [7:0] ctrl_read;

    // routine chosen once at reset release; later switch moves ignored
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            armed <= 1'b0;
            mode <= PBP_MODE_IDLE;
        end else if (!armed) begin
            armed <= 1'b1;
            mode <= pbp_decode_mode(
                {sw_d_i, sw_c_i, sw_b_i, sw_a_i});
        end
    end

    // program control register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            latch_arm <= PBP_CTRL_RESET[PBP_LATCH_BIT];
            high_voltage_apply <= PBP_CTRL_RESET[PBP_HV_BIT];
        end else if (reg_wr_i && reg_addr_i == PBP_CTRL_OFFSET) begin
            latch_arm <= reg_wdata_i[PBP_LATCH_BIT];
            // supply only if the latch bit is set in this same write
            high_voltage_apply <= reg_wdata_i[PBP_HV_BIT] &&
                reg_wdata_i[PBP_LATCH_BIT];
        end
    end

    always_comb begin
        ctrl_read = 8'h00;
        ctrl_read[PBP_LATCH_BIT] = latch_arm;
        ctrl_read[PBP_HV_BIT] = high_voltage_apply;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i && reg_addr_i == PBP_CTRL_OFFSET) begin
            reg_rdata_o <= ctrl_read;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // programming latches
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            latch_addr <= 13'h0000;
            latch_data <= 8'h00;
            latch_full <= 1'b0;
        end else if (!latch_arm) begin
            latch_full <= 1'b0;
        end else if (cpu_write_i && !latch_full) begin
            latch_addr <= cpu_addr_i;
            latch_data <= cpu_wdata_i;
            latch_full <= 1'b1;
        end
    end

    assign seq_write = state == ST_PROM_PROGRAM_CONTROL_PULSE || state == ST_SEC_PULSE;

    // array path: sequencer, then latched, else transparent cpu path
    always_comb begin
        if (seq_write) begin
            mem_addr_o = state == ST_SEC_PULSE ?
                PBP_OPTION_ADDR : addr;
            mem_wdata_o = state == ST_SEC_PULSE ?
                8'(1 << PBP_SECURE_BIT) : ext_data_i;
            mem_write_o = 1'b1;
        end else if (busy_o) begin
            // compares and dumps must read the walk address, not the cpu's
            mem_addr_o = state == ST_START ? PBP_OPTION_ADDR : addr;
            mem_wdata_o = 8'h00;
            mem_write_o = 1'b0;
        end else if (latch_arm && latch_full) begin
            mem_addr_o = latch_addr;
            mem_wdata_o = latch_data;
            mem_write_o = high_voltage_apply;
        end else begin
            mem_addr_o = cpu_addr_i;
            mem_wdata_o = cpu_wdata_i;
            mem_write_o = 1'b0;
        end
    end

    // supply switched on by the bit or by a sequencer pulse
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            vpp_enable_o <= 1'b0;
        end else begin
            vpp_enable_o <= high_voltage_apply || seq_write;
        end
    end

    pbp_uart_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .start_i(tx_start),
        .data_i(mem_rdata_i),
        .busy_o(tx_busy),
        .txd_o(txd_o)
    );

    // routine sequencer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state <= ST_START;
            addr <= 13'h0000;
            timer <= 20'h00000;
            security_lock <= 1'b0;
            red_led_o <= 1'b0;
            green_led_o <= 1'b0;
            tx_start <= 1'b0;
            load_count <= 8'h00;
            load_seen <= 8'h00;
            ram_write_o <= 1'b0;
            ram_addr_o <= 13'h0000;
            ram_wdata_o <= 8'h00;
            jump_valid_o <= 1'b0;
            jump_addr_o <= 13'h0000;
            fail_o <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            ram_write_o <= 1'b0;
            unique case (state)
                ST_START: begin
                    addr <= PBP_FIRST_ADDR;
                    if (armed) begin
                        // lock bit taken from the option byte on the array
                        security_lock <= mem_rdata_i[PBP_SECURE_BIT];
                        unique case (mode)
                            PBP_MODE_PROGRAM: begin
                                red_led_o <= 1'b1;
                                state <= ST_PROM_PROGRAM_CONTROL_RD;
                            end
                            PBP_MODE_VERIFY,
                            PBP_MODE_SECURE_VERIFY:
                                state <= ST_VER_RD;
                            PBP_MODE_SECURE_DUMP,
                            PBP_MODE_DUMP:
                                state <= ST_DUMP_RD;
                            PBP_MODE_LOAD_RAM: begin
                                ram_addr_o <= PBP_RAM_LOAD_ADDR;
                                state <= ST_LOAD;
                            end
                            PBP_MODE_EXEC_RAM: begin
                                jump_valid_o <= 1'b1;
                                jump_addr_o <= PBP_RAM_START_ADDR;
                                state <= ST_DONE;
                            end
                            PBP_MODE_IDLE:
                                state <= ST_DONE;
                        endcase
                    end
                end
                ST_PROM_PROGRAM_CONTROL_RD: begin
                    // skipped addresses and zero bytes cost no pulse
                    if (!pbp_implemented(addr) || ext_data_i == 8'h00) begin
                        if (addr == PBP_LAST_ADDR) begin
                            red_led_o <= 1'b0;
                            addr <= PBP_FIRST_ADDR;
                            state <= ST_VER_RD;
                        end else begin
                            addr <= addr + 13'h0001;
                        end
                    end else begin
                        timer <= 20'(PROM_PROGRAM_CONTROL_CYCLES - 1);
                        state <= ST_PROM_PROGRAM_CONTROL_PULSE;
                    end
                end
                ST_PROM_PROGRAM_CONTROL_PULSE: begin
                    if (timer == 20'h00000) begin
                        if (addr == PBP_LAST_ADDR) begin
                            red_led_o <= 1'b0;
                            addr <= PBP_FIRST_ADDR;
                            state <= ST_VER_RD;
                        end else begin
                            addr <= addr + 13'h0001;
                            state <= ST_PROM_PROGRAM_CONTROL_RD;
                        end
                    end else begin
                        timer <= timer - 20'h00001;
                    end
                end
                ST_VER_RD: begin
                    if (security_lock && mode != PBP_MODE_SECURE_VERIFY) begin
                        state <= ST_FAIL;
                    end else begin
                        state <= ST_VER_CMP;
                    end
                end
                ST_VER_CMP: begin
                    if (pbp_implemented(addr) &&
                        mem_rdata_i != ext_data_i) begin
                        fail_o <= 1'b1;
                        state <= ST_FAIL;
                    end else if (addr == PBP_LAST_ADDR) begin
                        if (mode == PBP_MODE_SECURE_VERIFY) begin
                            timer <= 20'(PROM_PROGRAM_CONTROL_CYCLES - 1);
                            state <= ST_SEC_PULSE;
                        end else begin
                            green_led_o <= 1'b1;
                            state <= ST_DONE;
                        end
                    end else begin
                        addr <= addr + 13'h0001;
                        state <= ST_VER_RD;
                    end
                end
                ST_SEC_PULSE: begin
                    if (timer == 20'h00000) begin
                        state <= ST_DONE;
                    end else begin
                        timer <= timer - 20'h00001;
                    end
                end
                ST_DUMP_RD: begin
                    if (security_lock) begin
                        state <= ST_FAIL;
                    end else if (!pbp_implemented(addr)) begin
                        addr <= addr + 13'h0001;
                    end else if (!tx_busy) begin
                        tx_start <= 1'b1;
                        state <= ST_DUMP_SEND;
                    end
                end
                ST_DUMP_SEND:
                    state <= ST_DUMP_WAIT;
                ST_DUMP_WAIT: begin
                    if (!tx_busy) begin
                        if (addr == PBP_LAST_ADDR) begin
                            if (mode == PBP_MODE_SECURE_DUMP) begin
                                timer <= 20'(PROM_PROGRAM_CONTROL_CYCLES - 1);
                                state <= ST_SEC_PULSE;
                            end else begin
                                state <= ST_DONE;
                            end
                        end else begin
                            addr <= addr + 13'h0001;
                            state <= ST_DUMP_RD;
                        end
                    end
                end
                ST_LOAD: begin
                    if (rxd_byte_valid_i) begin
                        ram_write_o <= 1'b1;
                        ram_wdata_o <= rxd_byte_i;
                        if (load_seen != 8'h00) begin
                            ram_addr_o <= ram_addr_o + 13'h0001;
                        end
                        if (load_seen == 8'h00) begin
                            load_count <= rxd_byte_i;
                        end
                        load_seen <= load_seen + 8'h01;
                        // a count larger than the data holds execution off
                        if (load_seen != 8'h00 &&
                            load_seen + 8'h01 == load_count) begin
                            jump_valid_o <= 1'b1;
                            jump_addr_o <= PBP_RAM_START_ADDR;
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                end
                ST_FAIL: begin
                end
            endcase
        end
    end

    // external bus shows the walk and freezes on failure
    assign ext_addr_o = addr;
    assign busy_o = state != ST_DONE && state != ST_FAIL;
endmodule

// File: pbp_props.sv
`timescale 1ns/1ns
module pbp_props (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [12:0] ext_addr_o,
    input wire logic [12:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic mem_write_o,
    input wire logic vpp_enable_o,
    input wire logic red_led_o,
    input wire logic green_led_o,
    input wire logic jump_valid_o,
    input wire logic [12:0] jump_addr_o,
    input wire logic busy_o,
    input wire logic fail_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // own copy of the map, so a slip in the design's helper shows
    logic mapped;
    assign mapped = (mem_addr_o >= 13'h0020 && mem_addr_o <= 13'h004f) ||
        (mem_addr_o >= 13'h0100 && mem_addr_o <= 13'h1eff) ||
        (mem_addr_o >= 13'h1ff0);
    a_read_slot_only: assert property (
        reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
        else $error("read data outside its slot");
    a_unused_bits_zero: assert property (
        $past(reg_rd_i) |-> (reg_rdata_o & 8'hfa) == 8'h00)
        else $error("unused control bit read as one");
    a_hv_needs_latch: assert property (
        $past(reg_rd_i) && reg_rdata_o[0] |-> reg_rdata_o[2])
        else $error("supply bit set without latch bit");
    a_vpp_on_write: assert property (
        reg_wr_i && reg_addr_i == 8'h1c && reg_wdata_i[2] &&
        reg_wdata_i[0] && !busy_o ##1 !reg_wr_i |-> ##1 vpp_enable_o)
        else $error("supply not switched on");
    a_vpp_off_write: assert property (
        reg_wr_i && reg_addr_i == 8'h1c && !reg_wdata_i[0] && !busy_o
        ##1 !reg_wr_i |-> ##1 !vpp_enable_o)
        else $error("supply not switched off");
    a_green_alone: assert property (
        green_led_o |-> !red_led_o && !fail_o)
        else $error("green lit with red or failure");
    a_fail_addr_held: assert property (
        fail_o ##1 fail_o |-> $stable(ext_addr_o))
        else $error("failing address moved");
    a_prom_program_control_mapped: assert property (
        mem_write_o && busy_o && mem_addr_o != 13'h1fdf |->
        mapped && mem_wdata_o != 8'h00)
        else $error("write to unmapped or blank cell");
    a_secure_pulse: assert property (
        mem_write_o && busy_o && mem_addr_o == 13'h1fdf |->
        mem_wdata_o == 8'h08 && !red_led_o)
        else $error("option write carries wrong value");
    a_jump_target: assert property (
        jump_valid_o |-> jump_addr_o == 13'h0051)
        else $error("jump to wrong address");
endmodule

// File: pbp_partner.sv
`timescale 1ns/1ns
module pbp_partner #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [12:0] ext_addr_i,
    output logic [7:0] ext_data_o,
    input wire logic [12:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    input wire logic mem_write_i,
    output logic [7:0] mem_rdata_o,
    input wire logic txd_i,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o
);
    logic [7:0] image [0:8191];
    logic [7:0] array [0:8191];
    logic [7:0] sh;
    logic ok;
    initial begin
        for (int i = 0; i < 8192; i++) begin
            image[i] = 8'h00;
            array[i] = 8'h00;
        end
        image[13'h0021] = 8'h5a;
        image[13'h0123] = 8'hc3;
        image[13'h1ffe] = 8'h7e;
        image[13'h0080] = 8'h99;
    end
    assign ext_data_o = image[ext_addr_i];
    assign mem_rdata_o = array[mem_addr_i];
    always @(posedge clk_i) begin
        if (mem_write_i) begin
            array[mem_addr_i] <= mem_wdata_i;
        end
    end
    // 8n1 receiver; a frame cut short by reset is dropped
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
        forever begin
            @(negedge txd_i);
            ok = resetn_i;
            repeat (BIT_CYCLES / 2) @(posedge clk_i);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CYCLES) @(posedge clk_i);
                ok = ok & resetn_i;
                if (i < 8) sh[i] = txd_i;
            end
            if (ok && txd_i) begin
                rx_byte_o <= sh;
                rx_valid_o <= 1'b1;
                @(posedge clk_i);
                rx_valid_o <= 1'b0;
            end
        end
    end
endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
    import pbp_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic [7:0] cpu_wdata_i = 8'h00, rxd_byte_i = 8'h00;
    logic [12:0] cpu_addr_i = 13'h1fdf;
    logic cpu_write_i = 1'b0, rxd_byte_valid_i = 1'b0, rd_d = 1'b0;
    logic [3:0] sw = 4'hf;
    logic [7:0] reg_rdata_o, ext_data_i, mem_wdata_o, mem_rdata_i;
    logic [7:0] ram_wdata_o, rx_byte;
    logic [12:0] ext_addr_o, mem_addr_o, ram_addr_o, jump_addr_o;
    logic mem_write_o, vpp_enable_o, red_led_o, green_led_o, txd_o;
    logic ram_write_o, jump_valid_o, busy_o, fail_o, rx_valid;
    logic red_seen, green_seen;
    logic [20:0] exp_q[$];
    logic [31:0] seed = 32'hb39e14cf;
    int err_total = 0, tests_run = 0, rx_count = 0, n;
    pbp_top #(.PROM_PROGRAM_CONTROL_CYCLES(4), .BIT_CYCLES(4)) DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sw_a_i(sw[0]), .sw_b_i(sw[1]),
        .sw_c_i(sw[2]), .sw_d_i(sw[3]), .cpu_addr_i(cpu_addr_i),
        .cpu_wdata_i(cpu_wdata_i), .cpu_write_i(cpu_write_i),
        .ext_addr_o(ext_addr_o), .ext_data_i(ext_data_i),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_write_o(mem_write_o), .mem_rdata_i(mem_rdata_i),
        .vpp_enable_o(vpp_enable_o), .red_led_o(red_led_o),
        .green_led_o(green_led_o), .txd_o(txd_o),
        .rxd_byte_valid_i(rxd_byte_valid_i), .rxd_byte_i(rxd_byte_i),
        .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o),
        .ram_write_o(ram_write_o), .jump_valid_o(jump_valid_o),
        .jump_addr_o(jump_addr_o), .busy_o(busy_o), .fail_o(fail_o));
    pbp_partner #(.BIT_CYCLES(4)) PART (
        .clk_i(clk_i), .resetn_i(resetn_i), .ext_addr_i(ext_addr_o),
        .ext_data_o(ext_data_i), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_write_i(mem_write_o),
        .mem_rdata_o(mem_rdata_i), .txd_i(txd_o), .rx_valid_o(rx_valid),
        .rx_byte_o(rx_byte));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic take(input logic [20:0] got);
        if (exp_q.size() == 0) begin
            chk(got, 21'h1fffff);
        end else begin
            chk(got, exp_q.pop_front());
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (rd_d === 1'b1) begin
            take({13'h0000, reg_rdata_o});
        end
        if (ram_write_o === 1'b1) begin
            take({ram_addr_o, ram_wdata_o});
        end
        if (rx_valid === 1'b1) begin
            rx_count++;
            take({13'h0000, rx_byte});
        end
        rd_d <= reg_rd_i;
    end
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        exp_q.push_back({13'h0000, d});
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask
    // switches move only in reset, then are scrambled to catch resampling
    task automatic start(input logic [3:0] mode);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        sw <= mode;
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sw <= ~mode;
        red_seen = 1'b0;
        green_seen = 1'b0;
    endtask
    task automatic finish_run;
        n = 0;
        while (busy_o === 1'b1 && n < 40000) begin
            @(posedge clk_i);
            red_seen = red_seen | red_led_o;
            green_seen = green_seen | green_led_o;
            n++;
        end
        chk({20'h0, busy_o}, 21'h0);
        repeat (2) @(posedge clk_i);
    endtask
    initial begin
        #(20 * 100000);
        err_total++;
        report_and_stop;
    end
    initial begin
        start(4'hf);
        reg_write(PBP_CTRL_OFFSET, 8'h01);
        reg_read(PBP_CTRL_OFFSET, 8'h00);
        reg_write(PBP_CTRL_OFFSET, 8'hff);
        reg_read(PBP_CTRL_OFFSET, 8'h05);
        chk({20'h0, vpp_enable_o}, 21'h1);
        reg_read(8'h55, 8'h00);
        reg_write(PBP_CTRL_OFFSET, 8'h04);
        seed = lfsr(seed);
        @(posedge clk_i);
        cpu_addr_i <= 13'h0123;
        cpu_wdata_i <= seed[7:0];
        cpu_write_i <= 1'b1;
        @(posedge clk_i);
        cpu_write_i <= 1'b0;
        cpu_addr_i <= 13'h0456;
        @(posedge clk_i);
        chk({mem_addr_o, mem_wdata_o}, {13'h0123, seed[7:0]});
        chk({20'h0, mem_write_o}, 21'h0);
        reg_write(PBP_CTRL_OFFSET, 8'h05);
        @(posedge clk_i);
        chk({20'h0, mem_write_o}, 21'h1);
        reg_write(PBP_CTRL_OFFSET, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({mem_addr_o, 7'h0, vpp_enable_o}, 21'h045600);
        cpu_addr_i <= 13'h1fdf;
        start(4'h0);
        finish_run;
        chk({18'h0, red_seen, red_led_o, green_led_o}, 21'h5);
        chk({13'h0, PART.array[13'h0021]}, 21'h5a);
        chk({13'h0, PART.array[13'h0123]}, 21'hc3);
        chk({13'h0, PART.array[13'h1ffe]}, 21'h7e);
        chk({13'h0, PART.array[13'h0080]}, 21'h0);
        PART.image[13'h0123] = 8'h3c;
        start(4'h4);
        finish_run;
        chk({fail_o, ext_addr_o, 4'h0, red_seen, green_seen, green_led_o},
            {1'b1, 13'h0123, 7'h00});
        PART.image[13'h0123] = 8'hc3;
        for (int i = 0; i < 3; i++) begin
            exp_q.push_back({13'h0000, PART.array[13'h0020 + 13'(i)]});
        end
        start(4'h6);
        chk({8'h00, ext_addr_o}, 21'h0020);
        n = 0;
        while (rx_count < 3 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk(21'(rx_count), 21'h3);
        start(4'h5);
        finish_run;
        chk({17'h0, fail_o, red_seen, green_seen, PART.array[13'h1fdf][3]},
            21'h1);
        start(4'h4);
        finish_run;
        chk({19'h0, green_seen, green_led_o}, 21'h0);
        n = rx_count;
        start(4'h6);
        repeat (88) @(posedge clk_i);
        chk(21'(rx_count - n), 21'h0);
        start(4'h7);
        repeat (20) @(posedge clk_i);
        chk({19'h0, red_led_o, green_led_o}, 21'h0);
        start(4'h2);
        seed = lfsr(seed);
        for (int i = 0; i < 4; i++) begin
            logic [7:0] b;
            b = (i == 0) ? 8'h04 : seed[8 * i +: 8];
            exp_q.push_back({13'h0050 + 13'(i), b});
            @(posedge clk_i);
            rxd_byte_i <= b;
            rxd_byte_valid_i <= 1'b1;
            @(posedge clk_i);
            rxd_byte_valid_i <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
        chk({jump_valid_o, 7'h0, jump_addr_o}, 21'h100051);
        start(4'h8);
        chk({jump_valid_o, 7'h0, jump_addr_o}, 21'h100051);
        report_and_stop;
    end
endmodule
bind pbp_top pbp_props u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ext_addr_o(ext_addr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_write_o(mem_write_o), .vpp_enable_o(vpp_enable_o),
    .red_led_o(red_led_o), .green_led_o(green_led_o),
    .jump_valid_o(jump_valid_o), .jump_addr_o(jump_addr_o),
    .busy_o(busy_o), .fail_o(fail_o));
